//--- src/hwa_pkg.sv
// Purpose: Shared constants and types for the handwheel axis arbiter.
// Assumes: APB with 32-bit data, 125 MHz pclk.
// Notes: Offsets are byte addresses of word registers.
package hwa_pkg;
	localparam int NUM_HW = 3;
	localparam int NUM_AXES = 32;
	localparam int PICK_MAX = 3;
	localparam int CLK_MHZ = 125;
	// Smoothing unit time in microseconds (56.8 ms) and its cycle count
	localparam int SMOOTH_UNIT_US = 56800;
	localparam int SMOOTH_UNIT_CYC = SMOOTH_UNIT_US * CLK_MHZ;
	localparam logic [5:0] SMOOTH_MAG_MAX = 6'h3b;
	localparam logic [15:0] MAG_MIN = 16'h0001;
	localparam logic [15:0] MAG_MAX = 16'h2710;
	localparam logic [15:0] MAG_DEFAULT = 16'h0001;
	localparam logic [15:0] ERR_HW_CONFLICT = 16'h00d6;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] TORQUE_HW_PCT = 16'h012c;
	localparam logic [15:0] TORQUE_RESET = 16'h012c;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_ACCEPT = 12'h004;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
	localparam logic [11:0] OFS_AXIS_ERR = 12'h010;
	localparam logic [11:0] OFS_TORQUE = 12'h014;
	localparam logic [11:0] OFS_ERR_CLR = 12'h018;
	localparam logic [11:0] OFS_HW_STATE = 12'h01c;
	localparam logic [11:0] OFS_SEL_BASE = 12'h020;
	localparam logic [11:0] OFS_SMOOTH_BASE = 12'h030;
	localparam logic [11:0] OFS_MAG_BASE = 12'h100;
	localparam logic [11:0] OFS_ERRCODE_BASE = 12'h200;
	localparam logic [11:0] OFS_WORD = 12'h004;
	// Field positions
	localparam int AXIS_ERR_FLAG_BIT = 8;
	localparam int HW_STATE_BITS = 2;

	typedef enum {HW_IDLE, HW_ACTIVE, HW_DECEL} hwa_state_t;

	// Interrupt events, one bit each in IRQ_STAT and IRQ_MASK
	typedef struct packed {
		logic decel_done;
		logic axis_set_err;
		logic conflict;
	} hwa_evt_t;
endpackage : hwa_pkg

//--- src/hwa_axis_pick.sv
// Purpose: Keeps at most PICK_MAX lowest-numbered set bits of an axis selection.
// Assumes: Purely combinational.
// Notes: Bit 0 is axis 1.
module hwa_axis_pick
	import hwa_pkg::*;
#(
	parameter int AXES = NUM_AXES,
	parameter int LIMIT = PICK_MAX
) (
	// Selection
	input wire logic [AXES-1:0] sel,
	// Result
	output logic [AXES-1:0] picked
);
	always_comb begin
		int n;
		n = 0;
		picked = '0;
		for (int a = 0; a < AXES; a++) begin
			if (sel[a] && n < LIMIT) begin
				picked[a] = 1'b1;
				n = n + 1;
			end
		end
	end
endmodule : hwa_axis_pick

//--- src/hwa_smooth_timer.sv
// Purpose: Times the smoothing deceleration of one handwheel.
// Assumes: start is a one-cycle pulse; mag is already clamped.
// Notes: Length is (mag + 1) units of UNIT_CYC cycles.
module hwa_smooth_timer
	import hwa_pkg::*;
#(
	parameter int UNIT_CYC = SMOOTH_UNIT_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	input wire logic [5:0] mag,
	// Status
	output logic running,
	output logic done
);
	logic [31:0] unit_cnt;
	logic [6:0] units_left;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
			done <= 1'b0;
			unit_cnt <= '0;
			units_left <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				running <= 1'b1;
				unit_cnt <= '0;
				units_left <= 7'(mag) + 7'h01;
			end else if (running) begin
				if (unit_cnt == 32'(UNIT_CYC - 1)) begin
					unit_cnt <= '0;
					units_left <= units_left - 7'h01;
					if (units_left == 7'h01) begin
						running <= 1'b0;
						done <= 1'b1;
					end
				end else begin
					unit_cnt <= unit_cnt + 32'h1;
				end
			end
		end
	end
endmodule : hwa_smooth_timer

//--- src/hwa_arbiter.sv
// Purpose: Decides which axes each handwheel drives and reports conflicts.
// Assumes: Inputs are synchronous to pclk; handwheel pulses are one-cycle strobes.
// Notes: Registers over APB with one wait state per access.
module hwa_arbiter
	import hwa_pkg::*;
#(
	parameter int UNIT_CYC = SMOOTH_UNIT_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Handwheel pulse inputs
	input wire logic [NUM_HW-1:0] hw_pulse,
	// Axis side
	input wire logic [NUM_AXES-1:0] axis_busy,
	input wire logic [NUM_AXES-1:0] axis_start_req,
	output logic [NUM_AXES-1:0] axis_start_grant,
	output logic [NUM_AXES-1:0] start_accept,
	output logic [NUM_AXES-1:0] axis_step,
	output logic [NUM_AXES-1:0][15:0] axis_step_mag,
	output logic [NUM_AXES-1:0][15:0] axis_torque_limit,
	// Interrupt
	output logic irq
);
	// Software-visible state
	logic [NUM_HW-1:0] hw_enable;
	logic [NUM_AXES-1:0] axis_sel [NUM_HW];
	logic [5:0] smooth_mag [NUM_HW];
	logic [15:0] pulse_mag [NUM_AXES];
	logic [15:0] err_code [NUM_AXES];
	logic [NUM_HW-1:0] handwheel_axis_error_store;
	logic handwheel_axis_error_flag;
	logic [15:0] torque_setting;
	hwa_evt_t irq_stat;
	hwa_evt_t irq_mask;

	// Arbitration state
	hwa_state_t hw_state [NUM_HW];
	logic [NUM_AXES-1:0] owned [NUM_HW];
	logic [NUM_HW-1:0] en_q;
	logic [NUM_AXES-1:0] picked [NUM_HW];
	logic [NUM_HW-1:0] decel_running;
	logic [NUM_HW-1:0] decel_done;
	logic [NUM_HW-1:0] decel_start;

	// Combinational decisions
	logic [NUM_AXES-1:0] next_take [NUM_HW];
	logic [NUM_AXES-1:0] conflict_axes;
	logic [NUM_AXES-1:0] bad_mag_axes;
	logic [NUM_HW-1:0] next_set_err;
	logic [NUM_AXES-1:0] owned_all;
	logic [NUM_AXES-1:0] active_all;

	// APB decode
	logic wr_done;
	logic rd_cycle;
	logic [31:0] next_rdata;
	logic next_slverr;
	logic rd_clear_irq;

	function automatic logic mag_bad(input logic [15:0] m);
		return (m < MAG_MIN) || (m > MAG_MAX);
	endfunction : mag_bad

	function automatic logic in_range(input logic [11:0] a, input logic [11:0] base,
		input int n);
		return (a >= base) && (a < base + 12'(n * 4));
	endfunction : in_range

	function automatic int word_idx(input logic [11:0] a, input logic [11:0] base);
		return int'((a - base) >> 2);
	endfunction : word_idx

	assign wr_done = psel && penable && pready && pwrite;
	assign rd_cycle = psel && penable && !pready;
	assign rd_clear_irq = rd_cycle && !pwrite && (paddr == OFS_IRQ_STAT);

	genvar gh;
	generate
		for (gh = 0; gh < NUM_HW; gh++) begin : g_hw
			hwa_axis_pick u_pick (
				.sel(axis_sel[gh]),
				.picked(picked[gh])
			);
			hwa_smooth_timer #(.UNIT_CYC(UNIT_CYC)) u_timer (
				.pclk(pclk),
				.presetn(presetn),
				.start(decel_start[gh]),
				.mag(smooth_mag[gh]),
				.running(decel_running[gh]),
				.done(decel_done[gh])
			);
		end
	endgenerate

	// Enable rise and fall evaluation; lower handwheel number wins a tie
	always_comb begin
		logic [NUM_AXES-1:0] claimed;
		logic [NUM_AXES-1:0] want;
		claimed = '0;
		want = '0;
		owned_all = '0;
		active_all = '0;
		conflict_axes = '0;
		bad_mag_axes = '0;
		next_set_err = '0;
		decel_start = '0;
		for (int h = 0; h < NUM_HW; h++) begin
			owned_all = owned_all | owned[h];
			if (hw_state[h] == HW_ACTIVE && hw_enable[h])
				active_all = active_all | owned[h];
		end
		claimed = owned_all;
		for (int h = 0; h < NUM_HW; h++) begin
			next_take[h] = '0;
			want = picked[h];
			if (hw_enable[h] && !en_q[h]) begin
				if (hw_state[h] == HW_IDLE) begin
					conflict_axes = conflict_axes | (want & (axis_busy | claimed));
					next_take[h] = want & ~axis_busy & ~claimed;
					claimed = claimed | next_take[h];
					for (int a = 0; a < NUM_AXES; a++) begin
						if (next_take[h][a] && mag_bad(pulse_mag[a])) begin
							bad_mag_axes[a] = 1'b1;
							next_set_err[h] = 1'b1;
						end
					end
				end else if (hw_state[h] == HW_DECEL) begin
					if (want == owned[h])
						conflict_axes = conflict_axes | owned[h];
					else
						next_set_err[h] = 1'b1;
				end
			end
			if (hw_state[h] == HW_ACTIVE && !hw_enable[h])
				decel_start[h] = 1'b1;
		end
	end

	// Per-handwheel state and owned axes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int h = 0; h < NUM_HW; h++) begin
				hw_state[h] <= HW_IDLE;
				owned[h] <= '0;
			end
			en_q <= '0;
		end else begin
			en_q <= hw_enable;
			for (int h = 0; h < NUM_HW; h++) begin
				case (hw_state[h])
					HW_IDLE: begin
						// An empty or fully refused selection stays idle
						if (next_take[h] != '0) begin
							hw_state[h] <= HW_ACTIVE;
							owned[h] <= next_take[h];
						end
					end
					HW_ACTIVE: begin
						if (decel_start[h])
							hw_state[h] <= HW_DECEL;
					end
					HW_DECEL: begin
						if (decel_done[h]) begin
							hw_state[h] <= HW_IDLE;
							owned[h] <= '0;
						end
					end
					default: hw_state[h] <= HW_IDLE;
				endcase
			end
		end
	end

	// Axis outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			axis_step <= '0;
			start_accept <= '0;
			axis_start_grant <= '0;
			for (int a = 0; a < NUM_AXES; a++) begin
				axis_step_mag[a] <= MAG_DEFAULT;
				axis_torque_limit[a] <= TORQUE_RESET;
			end
		end else begin
			start_accept <= owned_all;
			axis_start_grant <= axis_start_req & ~owned_all;
			for (int a = 0; a < NUM_AXES; a++) begin
				logic s;
				s = 1'b0;
				for (int h = 0; h < NUM_HW; h++) begin
					if (hw_pulse[h] && hw_enable[h] && hw_state[h] == HW_ACTIVE && owned[h][a])
						s = 1'b1;
				end
				axis_step[a] <= s;
				axis_torque_limit[a] <= owned_all[a] ? TORQUE_HW_PCT : torque_setting;
				for (int h = 0; h < NUM_HW; h++) begin
					if (next_take[h][a])
						axis_step_mag[a] <= bad_mag_axes[a] ? MAG_DEFAULT : pulse_mag[a];
				end
			end
		end
	end

	// Per-axis error codes; a new conflict wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int a = 0; a < NUM_AXES; a++)
				err_code[a] <= ERR_NONE;
		end else begin
			for (int a = 0; a < NUM_AXES; a++) begin
				if (conflict_axes[a])
					err_code[a] <= ERR_HW_CONFLICT;
				else if (wr_done && paddr == OFS_ERR_CLR && pwdata[a])
					err_code[a] <= ERR_NONE;
			end
		end
	end

	// Axis-setting error store and flag, write one to clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			handwheel_axis_error_store <= '0;
			handwheel_axis_error_flag <= 1'b0;
		end else begin
			logic [NUM_HW-1:0] clr;
			logic fclr;
			clr = (wr_done && paddr == OFS_AXIS_ERR) ? pwdata[NUM_HW-1:0] : '0;
			fclr = wr_done && paddr == OFS_AXIS_ERR && pwdata[AXIS_ERR_FLAG_BIT];
			handwheel_axis_error_store <= (handwheel_axis_error_store & ~clr) | next_set_err;
			handwheel_axis_error_flag <= (handwheel_axis_error_flag && !fclr) || (|next_set_err);
		end
	end

	// Interrupt status: read clears, a same-cycle event still lands
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			hwa_evt_t ev;
			ev.conflict = |conflict_axes;
			ev.axis_set_err = |next_set_err;
			ev.decel_done = |decel_done;
			irq_stat <= (rd_clear_irq ? hwa_evt_t'('0) : irq_stat) | ev;
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Software register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_enable <= '0;
			irq_mask <= '0;
			torque_setting <= TORQUE_RESET;
			for (int h = 0; h < NUM_HW; h++) begin
				axis_sel[h] <= '0;
				smooth_mag[h] <= '0;
			end
			for (int a = 0; a < NUM_AXES; a++)
				pulse_mag[a] <= MAG_DEFAULT;
		end else if (wr_done) begin
			if (paddr == OFS_CTRL) begin
				hw_enable <= pwdata[NUM_HW-1:0];
			end else if (paddr == OFS_IRQ_MASK) begin
				irq_mask <= hwa_evt_t'(pwdata[$bits(hwa_evt_t)-1:0]);
			end else if (paddr == OFS_TORQUE) begin
				torque_setting <= pwdata[15:0];
			end else if (in_range(paddr, OFS_SEL_BASE, NUM_HW)) begin
				axis_sel[word_idx(paddr, OFS_SEL_BASE)] <= pwdata[NUM_AXES-1:0];
			end else if (in_range(paddr, OFS_SMOOTH_BASE, NUM_HW)) begin
				// Clamping keeps the time constant inside its documented span
				smooth_mag[word_idx(paddr, OFS_SMOOTH_BASE)] <=
					(pwdata[5:0] > SMOOTH_MAG_MAX || pwdata[31:6] != '0) ?
					SMOOTH_MAG_MAX : pwdata[5:0];
			end else if (in_range(paddr, OFS_MAG_BASE, NUM_AXES)) begin
				// Values above 16 bits alias; the range check sees the low half
				pulse_mag[word_idx(paddr, OFS_MAG_BASE)] <= pwdata[15:0];
			end
		end
	end

	// Read mux and unmapped-address detection
	always_comb begin
		next_rdata = '0;
		next_slverr = 1'b0;
		if (paddr == OFS_CTRL) begin
			next_rdata[NUM_HW-1:0] = hw_enable;
		end else if (paddr == OFS_ACCEPT) begin
			next_rdata[NUM_AXES-1:0] = owned_all;
		end else if (paddr == OFS_IRQ_STAT) begin
			next_rdata[$bits(hwa_evt_t)-1:0] = irq_stat;
		end else if (paddr == OFS_IRQ_MASK) begin
			next_rdata[$bits(hwa_evt_t)-1:0] = irq_mask;
		end else if (paddr == OFS_AXIS_ERR) begin
			next_rdata[NUM_HW-1:0] = handwheel_axis_error_store;
			next_rdata[AXIS_ERR_FLAG_BIT] = handwheel_axis_error_flag;
		end else if (paddr == OFS_TORQUE) begin
			next_rdata[15:0] = torque_setting;
		end else if (paddr == OFS_ERR_CLR) begin
			next_rdata = '0;
		end else if (paddr == OFS_HW_STATE) begin
			for (int h = 0; h < NUM_HW; h++)
				next_rdata[h*HW_STATE_BITS +: HW_STATE_BITS] = HW_STATE_BITS'(hw_state[h]);
		end else if (in_range(paddr, OFS_SEL_BASE, NUM_HW)) begin
			next_rdata[NUM_AXES-1:0] = axis_sel[word_idx(paddr, OFS_SEL_BASE)];
		end else if (in_range(paddr, OFS_SMOOTH_BASE, NUM_HW)) begin
			next_rdata[5:0] = smooth_mag[word_idx(paddr, OFS_SMOOTH_BASE)];
		end else if (in_range(paddr, OFS_MAG_BASE, NUM_AXES)) begin
			next_rdata[15:0] = pulse_mag[word_idx(paddr, OFS_MAG_BASE)];
		end else if (in_range(paddr, OFS_ERRCODE_BASE, NUM_AXES)) begin
			next_rdata[15:0] = err_code[word_idx(paddr, OFS_ERRCODE_BASE)];
		end else begin
			next_slverr = 1'b1;
		end
		if (paddr[1:0] != 2'h0)
			next_slverr = 1'b1;
	end

	// One wait state: answer is registered, so every output stays a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= rd_cycle;
			pslverr <= rd_cycle && next_slverr;
			if (rd_cycle && !pwrite)
				prdata <= next_slverr ? 32'h0 : next_rdata;
		end
	end
endmodule : hwa_arbiter

//--- tb/hwa_arbiter_checker.sv
// Purpose: Port assertions for the handwheel axis arbiter.
// Assumes: One pclk domain, presetn active low.
// Notes: Bound into every arbiter instance.
module hwa_arbiter_checker
	import hwa_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Axis side
	input wire logic [NUM_HW-1:0] hw_pulse,
	input wire logic [NUM_AXES-1:0] axis_start_grant,
	input wire logic [NUM_AXES-1:0] axis_start_req,
	input wire logic [NUM_AXES-1:0] start_accept,
	input wire logic [NUM_AXES-1:0] axis_step,
	input wire logic [NUM_AXES-1:0][15:0] axis_step_mag,
	input wire logic [NUM_AXES-1:0][15:0] axis_torque_limit
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_torque;
		start_accept[0] |-> axis_torque_limit[0] == TORQUE_HW_PCT;
	endproperty
	a_torque: assert property (p_torque) else $error("torque not forced");
	property p_grant;
		// Grant is last cycle's request minus the axes owned then
		axis_start_grant == ($past(axis_start_req) & ~start_accept);
	endproperty
	a_grant: assert property (p_grant) else $error("owned axis granted");
	property p_step_own;
		(axis_step & ~start_accept) == '0;
	endproperty
	a_step_own: assert property (p_step_own) else $error("step on free axis");
	property p_step_cause;
		axis_step != '0 |-> $past(hw_pulse) != '0;
	endproperty
	a_step_cause: assert property (p_step_cause) else $error("step without pulse");
	property p_mag;
		axis_step[0] |-> axis_step_mag[0] inside {[MAG_MIN:MAG_MAX]};
	endproperty
	a_mag: assert property (p_mag) else $error("step magnification out of range");
	property p_pick;
		$countones(start_accept) <= NUM_HW * PICK_MAX;
	endproperty
	a_pick: assert property (p_pick) else $error("too many axes owned");
	property p_ready;
		psel && $rose(penable) |-> !pready ##1 pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready timing wrong");
	property p_ready_one;
		pready |=> !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready held too long");
	property p_misalign;
		psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr;
	endproperty
	a_misalign: assert property (p_misalign) else $error("misaligned access accepted");
endmodule : hwa_arbiter_checker

bind hwa_arbiter hwa_arbiter_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.hw_pulse(hw_pulse), .axis_start_grant(axis_start_grant),
	.axis_start_req(axis_start_req), .start_accept(start_accept),
	.axis_step(axis_step), .axis_step_mag(axis_step_mag),
	.axis_torque_limit(axis_torque_limit));

//--- tb/hwa_partner.sv
// Purpose: Handwheels and axis motion side facing the arbiter.
// Assumes: Bench commands change just after a pclk edge.
// Notes: Slow mode leaves four idle cycles between pulses.
module hwa_partner
	import hwa_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Commands
	input wire logic [NUM_HW-1:0] turn,
	input wire logic slow,
	input wire logic [NUM_AXES-1:0] jog,
	input wire logic [NUM_AXES-1:0] want,
	// Toward the arbiter
	output logic [NUM_HW-1:0] hw_pulse,
	output logic [NUM_AXES-1:0] axis_busy,
	output logic [NUM_AXES-1:0] axis_start_req,
	output int sent0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] gap;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 3'h0;
			hw_pulse <= '0;
			sent0 <= 0;
		end else begin
			gap <= (gap == 3'h4 || !slow) ? 3'h0 : gap + 3'h1;
			hw_pulse <= (gap == 3'h0) ? turn : '0;
			if (gap == 3'h0 && turn[0])
				sent0 <= sent0 + 1;
		end
	end
	// Program starts are only asked for axes not already moving
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			axis_busy <= '0;
			axis_start_req <= '0;
		end else begin
			axis_busy <= jog;
			axis_start_req <= want & ~jog;
		end
	end
endmodule : hwa_partner

//--- tb/tb_handwheel_axis_arbiter.sv
// Purpose: Self-checking bench for the handwheel axis arbiter.
// Assumes: Smoothing unit shortened to 4 cycles.
// Notes: Expected ownership comes from the pick model below.
module tb_handwheel_axis_arbiter;
	timeunit 1ns;
	timeprecision 1ps;
	import hwa_pkg::*;
	localparam int UCYC = 4;
	localparam int DECEL = (59 + 1) * UCYC;
	logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, irq, slow, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, sel0, mag5, acc;
	logic [NUM_HW-1:0] hw_pulse, turn;
	logic [NUM_AXES-1:0] axis_busy, axis_start_req, axis_start_grant, start_accept;
	logic [NUM_AXES-1:0] axis_step, jog, want;
	logic [NUM_AXES-1:0][15:0] axis_step_mag, axis_torque_limit;
	int seed, sent0, n, fails, tests_run;
	int stepc [NUM_AXES];
	always #4 pclk = ~pclk;
	hwa_arbiter #(.UNIT_CYC(UCYC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hw_pulse(hw_pulse), .axis_busy(axis_busy),
		.axis_start_req(axis_start_req), .axis_start_grant(axis_start_grant),
		.start_accept(start_accept), .axis_step(axis_step), .axis_step_mag(axis_step_mag),
		.axis_torque_limit(axis_torque_limit), .irq(irq));
	hwa_partner u_prt (.pclk(pclk), .presetn(presetn), .turn(turn), .slow(slow), .jog(jog),
		.want(want), .hw_pulse(hw_pulse), .axis_busy(axis_busy),
		.axis_start_req(axis_start_req), .sent0(sent0));
	always @(posedge pclk)
		for (int i = 0; i < NUM_AXES; i++)
			if (axis_step[i] === 1'b1) stepc[i]++;
	function automatic logic [31:0] pick(input logic [31:0] s);
		int k;
		pick = '0;
		k = 0;
		for (int i = 0; i < NUM_AXES; i++)
			if (s[i] && k < PICK_MAX) begin
				pick[i] = 1'b1;
				k++;
			end
	endfunction : pick
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			$display("ERROR %0t bus answer timed out", $time);
			fails++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Enable changes are judged four edges after the write lands
	task ctrl(input logic [2:0] e);
		apb(1'b1, OFS_CTRL, {29'h0, e});
		repeat (4) @(posedge pclk);
		#1;
	endtask : ctrl
	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		wrap_up();
	end
	initial begin
		seed = 66544;
		{presetn, psel, penable, pwrite, slow} = '0;
		{paddr, pwdata, turn, jog, want} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_TORQUE, '0);
		chk(rd, 32'(TORQUE_RESET));
		apb(1'b0, 12'hffc, '0);
		chk(32'(er), 32'h1);
		// Misaligned word access must be refused and read as zero
		apb(1'b0, OFS_TORQUE + 12'h002, '0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, OFS_SMOOTH_BASE, 32'h3f);
		apb(1'b0, OFS_SMOOTH_BASE, '0);
		chk(rd, 32'(SMOOTH_MAG_MAX));
		mag5 = 32'(1 + ($unsigned($random(seed)) % 10000));
		apb(1'b1, OFS_MAG_BASE, '0);
		apb(1'b1, OFS_MAG_BASE + 12'h010, mag5);
		sel0 = 32'h171 | ($random(seed) & 32'hffff_fe00);
		apb(1'b1, OFS_SEL_BASE, sel0);
		apb(1'b1, OFS_IRQ_MASK, 32'h7);
		ctrl(3'b001);
		acc = pick(sel0);
		chk(start_accept, acc);
		chk(32'(axis_torque_limit[4]), 32'(TORQUE_HW_PCT));
		apb(1'b0, OFS_AXIS_ERR, '0);
		chk(rd, 32'h101);
		// Second wheel claims a held axis and a jogging one
		jog <= 32'h80;
		apb(1'b1, OFS_SEL_BASE + 12'h004, 32'h90);
		ctrl(3'b011);
		chk(start_accept, acc);
		apb(1'b0, OFS_ERRCODE_BASE + 12'h010, '0);
		chk(rd, 32'(ERR_HW_CONFLICT));
		apb(1'b0, OFS_ERRCODE_BASE + 12'h01c, '0);
		chk(rd, 32'(ERR_HW_CONFLICT));
		turn <= 3'b011;
		slow <= 1'($random(seed));
		want <= acc | 32'h200;
		repeat (60) @(posedge pclk);
		turn <= '0;
		repeat (4) @(posedge pclk);
		chk(axis_start_grant, 32'h200);
		want <= '0;
		chk(32'(stepc[4]), 32'(sent0));
		chk(32'(stepc[0]), 32'(sent0));
		chk(32'(stepc[7]), 32'h0);
		chk(32'(axis_step_mag[4]), mag5);
		chk(32'(axis_step_mag[0]), 32'h1);
		chk(32'(irq), 32'h1);
		apb(1'b0, OFS_IRQ_STAT, '0);
		chk(rd, 32'h3);
		repeat (3) @(posedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'b0, OFS_ERRCODE_BASE + 12'h010, '0);
		chk(rd, 32'(ERR_HW_CONFLICT));
		apb(1'b1, OFS_ERR_CLR, 32'h90);
		apb(1'b1, OFS_AXIS_ERR, 32'h101);
		apb(1'b1, OFS_MAG_BASE, 32'h1);
		apb(1'b0, OFS_ERRCODE_BASE + 12'h010, '0);
		chk(rd, 32'(ERR_NONE));
		jog <= '0;
		apb(1'b1, OFS_SEL_BASE + 12'h004, 32'h80);
		ctrl(3'b001);
		repeat (10) @(posedge pclk);
		ctrl(3'b011);
		acc[7] = 1'b1;
		chk(start_accept, acc);
		apb(1'b1, OFS_CTRL, 32'h2);
		n = 0;
		while (start_accept[0] !== 1'b0 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(n >= DECEL && n <= DECEL + 8), 32'h1);
		ctrl(3'b011);
		chk(start_accept, acc);
		apb(1'b1, OFS_CTRL, 32'h2);
		ctrl(3'b011);
		apb(1'b0, OFS_ERRCODE_BASE, '0);
		chk(rd, 32'(ERR_HW_CONFLICT));
		apb(1'b1, OFS_CTRL, 32'h2);
		apb(1'b1, OFS_SEL_BASE, 32'h200);
		ctrl(3'b011);
		apb(1'b0, OFS_AXIS_ERR, '0);
		chk(rd, 32'h101);
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (300) @(posedge pclk);
		ctrl(3'b100);
		chk(start_accept, '0);
		wrap_up();
	end
endmodule : tb_handwheel_axis_arbiter
